/* dtrw_channel.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dtrw_map.svh"
module dtrw_channel #(
  parameter int PRE_LEN = `DTRW_PRE_LEN
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_unit_sel,
  input  wire logic [7:0]  i_track_addr_in,
  input  wire logic        i_spare_en,
  input  wire logic [6:0]  i_spare_addr,
  input  wire logic [2:0]  i_spare_x_sel,
  input  wire logic        i_spare_y_sel,
  input  wire logic        i_write_cmd,
  input  wire logic        i_wr_clk,
  input  wire logic        i_wr_data,
  input  wire logic        i_read_cmd,
  input  wire logic        i_raw_read_pulses,
  input  wire logic [2:0]  i_supply_ok,
  input  wire logic        i_at_speed,
  input  wire logic        i_bus_term,
  input  wire logic        i_illegal_addr,
  output logic [7:0]       o_x_lines,
  output logic [15:0]      o_y_lines,
  output logic [7:0]       o_spare_x,
  output logic [1:0]       o_spare_y,
  output logic             o_surface_select_bit,
  output logic             o_wr_buf_ready,
  output logic             o_preamble_ser_n,
  output logic             o_write_pulse,
  output logic             o_write_current,
  output logic             o_threshold_diode_gate,
  output logic             o_threshold_switch_on,
  output logic             o_threshold_hold,
  output logic             o_separator_enable,
  output logic             o_osc_halt_restart,
  output logic             o_separator_pretrack_clock,
  output logic             o_sep_clk_x2,
  output logic             o_sep_clk_x1,
  output logic             o_phase_sample,
  output logic             o_deglitched_read_bits,
  output logic             o_rd_data,
  output logic             o_rd_clk,
  output logic             o_rd_clk_en,
  output logic             o_ready_n,
  output logic             o_illegal_out
);

  // -----------------------------------------------
  // helpers
  // -----------------------------------------------
  function automatic logic [15:0] onehot16(input logic [3:0] v);
    onehot16 = 16'h0001 << v;
  endfunction

  // -----------------------------------------------
  // pin synchronisers
  // -----------------------------------------------
  localparam int SW = 32;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sy1_q;
  logic [SW-1:0] sy2_q;
  assign pin_raw = {i_unit_sel, i_track_addr_in, i_write_cmd, i_wr_clk,
                    i_wr_data, i_read_cmd, i_raw_read_pulses, i_supply_ok,
                    i_at_speed, i_bus_term, i_illegal_addr, i_spare_en,
                    i_spare_y_sel, i_spare_x_sel, i_spare_addr};

  // two flops per pin input
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else begin
      sy1_q <= pin_raw;
      sy2_q <= sy1_q;
    end
  end

  logic       s_sel;
  logic [7:0] s_addr;
  logic       s_wcmd;
  logic       s_wclk;
  logic       s_wdat;
  logic       s_rcmd;
  logic       s_rpls;
  logic [4:0] s_mon;
  logic       s_ill;
  logic       s_spen;
  logic       s_spy;
  logic [2:0] s_spx;
  logic [6:0] s_spa;
  assign {s_sel, s_addr, s_wcmd, s_wclk, s_wdat, s_rcmd, s_rpls, s_mon,
          s_ill, s_spen, s_spy, s_spx, s_spa} = sy2_q;

  // -----------------------------------------------
  // edge detect and status
  // -----------------------------------------------
  logic wclk_d1_q;
  logic rpls_d1_q;
  logic wclk_rise;
  logic rpls_rise;
  logic rdy_ok;
  assign wclk_rise = s_wclk & ~wclk_d1_q;
  assign rpls_rise = s_rpls & ~rpls_d1_q;
  assign rdy_ok    = &s_mon;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wclk_d1_q <= 1'b0;
      rpls_d1_q <= 1'b0;
    end else begin
      wclk_d1_q <= s_wclk;
      rpls_d1_q <= s_rpls;
    end
  end

  // ready and illegal status outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready_n     <= 1'b1;
      o_illegal_out <= 1'b0;
    end else begin
      o_ready_n     <= ~rdy_ok;
      o_illegal_out <= s_ill;
    end
  end

  // -----------------------------------------------
  // cell phase counter (x4 oscillator)
  // -----------------------------------------------
  dtrw_pkg::dtrw_wr_state_t ws_q;
  dtrw_pkg::dtrw_rd_state_t rs_q;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic       tick;
  logic [1:0] dly_q;
  logic       dly_pls;
  logic       sep_on;
  assign tick    = (ph_q == `DTRW_PH_LAST);
  assign dly_pls = dly_q[1];
  assign sep_on  = (rs_q == dtrw_pkg::R_LOCK) || (rs_q == dtrw_pkg::R_DATA);

  // phase next value: pretrack, halt, in-phase restart
  always_comb begin
    ph_d = ph_q + 2'h1;
    if (rs_q == dtrw_pkg::R_HALT) begin
      ph_d = dly_pls ? 2'h0 : ph_q;
    end else if (sep_on) begin
      if (dly_pls) begin
        ph_d = 2'h0;
      end
    end else if (wclk_rise) begin
      ph_d = 2'h0;
    end
  end

  // divided clocks and pretrack strobe
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ph_q                       <= 2'h0;
      o_sep_clk_x2               <= 1'b0;
      o_sep_clk_x1               <= 1'b0;
      o_separator_pretrack_clock <= 1'b0;
    end else begin
      ph_q                       <= ph_d;
      o_sep_clk_x2               <= ph_d[0];
      o_sep_clk_x1               <= ph_d[1];
      o_separator_pretrack_clock <= wclk_rise & ~o_separator_enable;
    end
  end

  // -----------------------------------------------
  // address latch and head matrix
  // -----------------------------------------------
  logic [7:0] addr_q;
  logic       spare_hit;
  logic [15:0] xh;
  assign spare_hit = s_spen && (addr_q[6:0] == s_spa);
  assign xh        = onehot16({1'b0, addr_q[6:4]});

  // hold address while a write is in progress
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_q <= 8'h00;
    end else if (ws_q == dtrw_pkg::W_IDLE) begin
      addr_q <= s_addr;
    end
  end

  // normal or spare line drive
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_x_lines            <= 8'h00;
      o_y_lines            <= 16'h0000;
      o_spare_x            <= 8'h00;
      o_spare_y            <= 2'h0;
      o_surface_select_bit <= 1'b0;
    end else begin
      o_surface_select_bit <= addr_q[7];
      if (spare_hit) begin
        o_x_lines <= 8'h00;
        o_y_lines <= 16'h0000;
        o_spare_x <= 8'h01 << s_spx;
        o_spare_y <= s_spy ? 2'h2 : 2'h1;
      end else begin
        o_x_lines <= xh[7:0];
        o_y_lines <= onehot16(addr_q[3:0]);
        o_spare_x <= 8'h00;
        o_spare_y <= 2'h0;
      end
    end
  end

  // -----------------------------------------------
  // two-entry write data buffer
  // -----------------------------------------------
  logic [1:0] buf_q;
  logic [1:0] cnt_q;
  logic       wp_q;
  logic       rp_q;
  logic       push;
  logic       pop;
  logic       buf_vld;
  logic       wr_act;
  logic       cmd_act;
  assign cmd_act = s_sel & s_wcmd;
  assign wr_act  = (ws_q == dtrw_pkg::W_PRE) || (ws_q == dtrw_pkg::W_DATA);
  assign buf_vld = (cnt_q != 2'h0);
  assign push    = wr_act & s_sel & wclk_rise & (cnt_q != 2'h2);
  assign pop     = (ws_q == dtrw_pkg::W_DATA) & tick & buf_vld;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      buf_q <= 2'h0;
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= s_wdat;
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (ws_q == dtrw_pkg::W_IDLE) begin
        cnt_q <= 2'h0;
        wp_q  <= 1'b0;
        rp_q  <= 1'b0;
      end else begin
        cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  // ready goes low when full, so the controller holds its clock
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wr_buf_ready <= 1'b0;
    end else begin
      o_wr_buf_ready <= wr_act && !(cnt_q == 2'h2 ||
                        (cnt_q == 2'h1 && push && !pop));
    end
  end

  // -----------------------------------------------
  // write sequencer
  // -----------------------------------------------
  logic [7:0] pre_cnt_q;
  logic [4:0] chain_q;
  logic       cur_q;
  logic       prev_q;
  logic       wen;
  logic       gate;
  logic       pre_last;
  assign wen      = wr_act;
  assign gate     = wen | (|chain_q);
  assign pre_last = (pre_cnt_q == 8'(PRE_LEN - 1));

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ws_q      <= dtrw_pkg::W_IDLE;
      pre_cnt_q <= 8'h00;
      cur_q     <= 1'b0;
      prev_q    <= 1'b0;
    end else if (!rdy_ok) begin
      ws_q <= dtrw_pkg::W_IDLE;
    end else if (tick) begin
      prev_q <= cur_q;
      unique case (ws_q)
        dtrw_pkg::W_IDLE: begin
          cur_q <= 1'b0;
          if (cmd_act && rs_q == dtrw_pkg::R_IDLE) begin
            ws_q      <= dtrw_pkg::W_PRE;
            pre_cnt_q <= 8'h01;
            cur_q     <= (PRE_LEN > 1);
          end
        end
        dtrw_pkg::W_PRE: begin
          cur_q     <= ~pre_last;
          pre_cnt_q <= pre_cnt_q + 8'h01;
          if (pre_last) begin
            ws_q <= dtrw_pkg::W_DATA;
          end
        end
        dtrw_pkg::W_DATA: begin
          cur_q <= buf_vld ? buf_q[rp_q] : 1'b0;
          if (!cmd_act && !buf_vld) begin
            ws_q  <= dtrw_pkg::W_POST;
            cur_q <= 1'b0;
          end
        end
        dtrw_pkg::W_POST: begin
          cur_q <= 1'b0;
          if (chain_q == 5'h00) begin
            ws_q <= dtrw_pkg::W_IDLE;
          end
        end
      endcase
    end
  end

  // write enable delay chain, five cells deep
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chain_q <= 5'h00;
    end else if (!rdy_ok) begin
      chain_q <= 5'h00;
    end else if (tick) begin
      chain_q <= {chain_q[3:0], wen};
    end
  end

  // MFM encoder and write driver
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_write_pulse    <= 1'b0;
      o_write_current  <= 1'b0;
      o_preamble_ser_n <= 1'b1;
    end else begin
      o_write_current  <= gate & rdy_ok & ~s_ill;
      o_preamble_ser_n <= ~((ws_q == dtrw_pkg::W_PRE) & cur_q);
      if (ph_q == `DTRW_PH_MID) begin
        o_write_pulse <= gate & cur_q;
      end else if (ph_q == 2'h0) begin
        o_write_pulse <= gate & ~cur_q & ~prev_q;
      end else begin
        o_write_pulse <= 1'b0;
      end
    end
  end

  // -----------------------------------------------
  // read sequencer
  // -----------------------------------------------
  logic [3:0] rcnt_q;
  logic       rd_req;
  logic       latch_q;
  logic       std_q;
  logic       bit_stb;
  logic       seen_one_q;
  logic       peak_win;
  assign peak_win = (rs_q == dtrw_pkg::R_PRESET) && (rcnt_q < 4'(`DTRW_PEAK_CELLS));
  assign rd_req  = s_sel & s_rcmd;
  assign bit_stb = (ph_q == `DTRW_PH_MID) & sep_on;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rs_q       <= dtrw_pkg::R_IDLE;
      rcnt_q     <= 4'h0;
      seen_one_q <= 1'b0;
    end else if (!rd_req) begin
      rs_q       <= dtrw_pkg::R_IDLE;
      rcnt_q     <= 4'h0;
      seen_one_q <= 1'b0;
    end else begin
      unique case (rs_q)
        dtrw_pkg::R_IDLE: begin
          if (ws_q == dtrw_pkg::W_IDLE) begin
            rs_q <= dtrw_pkg::R_PRESET;
          end
        end
        dtrw_pkg::R_PRESET: begin
          if (tick) begin
            rcnt_q <= rcnt_q + 4'h1;
            if (rcnt_q == 4'(`DTRW_SEP_CELLS - 1)) begin
              rs_q <= dtrw_pkg::R_HALT;
            end
          end
        end
        dtrw_pkg::R_HALT: begin
          if (dly_pls) begin
            rs_q <= dtrw_pkg::R_LOCK;
          end
        end
        dtrw_pkg::R_LOCK: begin
          if (bit_stb) begin
            if (std_q) begin
              seen_one_q <= 1'b1;
            end else if (seen_one_q) begin
              rs_q <= dtrw_pkg::R_DATA;
            end
          end
        end
        dtrw_pkg::R_DATA: begin
          rs_q <= dtrw_pkg::R_DATA;
        end
      endcase
    end
  end

  // threshold sampler and separator controls
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_threshold_diode_gate <= 1'b0;
      o_threshold_switch_on  <= 1'b0;
      o_threshold_hold       <= 1'b0;
      o_separator_enable     <= 1'b0;
      o_osc_halt_restart     <= 1'b0;
    end else begin
      o_threshold_diode_gate <= peak_win;
      o_threshold_switch_on  <= peak_win;
      o_threshold_hold       <= (rs_q != dtrw_pkg::R_IDLE) && !peak_win;
      o_separator_enable     <= (rs_q != dtrw_pkg::R_IDLE) &&
                                (rs_q != dtrw_pkg::R_PRESET);
      o_osc_halt_restart     <= (rs_q == dtrw_pkg::R_HALT);
    end
  end

  // -----------------------------------------------
  // data separator
  // -----------------------------------------------
  // half-cell delay line on read pulses
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dly_q <= 2'h0;
    end else begin
      dly_q <= {dly_q[0], rpls_rise};
    end
  end

  // data latch, deglitch and phase sample
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_q        <= 1'b0;
      std_q          <= 1'b0;
      o_phase_sample <= 1'b0;
    end else begin
      if (dly_pls) begin
        latch_q <= 1'b1;
      end else if (ph_q == 2'h1) begin
        latch_q <= 1'b0;
      end
      if (ph_q == 2'h1) begin
        std_q <= latch_q;
      end
      if (dly_pls && sep_on) begin
        o_phase_sample <= ph_q[0];
      end
    end
  end

  // NRZ strobe, read clock gating
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_deglitched_read_bits <= 1'b0;
      o_rd_data              <= 1'b0;
      o_rd_clk               <= 1'b0;
      o_rd_clk_en            <= 1'b0;
    end else begin
      o_deglitched_read_bits <= std_q;
      o_rd_clk_en            <= rd_req && (rs_q == dtrw_pkg::R_DATA);
      o_rd_clk               <= rd_req && (rs_q == dtrw_pkg::R_DATA) &&
                                ph_d[1];
      if (bit_stb && rs_q == dtrw_pkg::R_DATA) begin
        o_rd_data <= std_q;
      end else if (rs_q != dtrw_pkg::R_DATA) begin
        o_rd_data <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* dtrw_map.svh */
// Overview of operation
// - latch 8-bit track address during writes
// - low 4 bits to Y, next 3 to X
// - top address bit selects disc surface
// - spared address drives spare lines instead
// - write command records preamble before data
// - five-cell postamble follows last data bit
// - postamble comes from delayed write enable
// - MFM pulse mid-cell for 1, boundary for 0
// - boundary pulse only between two zeros
// - not ready clears delay, drops write current
// - illegal address blocks writing, ready unaffected
// - write command and data honoured only when unit selected
// - preamble serializer low for 1, high for 0
// - preamble bits never reach read data
// - threshold preset at once, separator after 9
// - oscillator tracks write clock, restarts on data
// - x4 oscillator divided to x2 and x1
// - read pulses delayed half cell before latch
// - phase compare samples only with latched pulse
// - deglitch on inverted x2, NRZ on x1
// - flag zero ends preamble, enables read clock
// - read clock only during a read
// - peak gate five bits, then hold threshold
// - ready needs all five monitored conditions
`ifndef DTRW_MAP_SVH
`define DTRW_MAP_SVH
`define DTRW_CLK_NS      100
`define DTRW_CELL_NS     400
`define DTRW_CELL_CYC    (`DTRW_CELL_NS / `DTRW_CLK_NS)
`define DTRW_PRE_LEN     16
`define DTRW_POST_CELLS  5
`define DTRW_SEP_CELLS   9
`define DTRW_PEAK_CELLS  5
`define DTRW_HALF_CYC    (`DTRW_CELL_CYC / 2)
`define DTRW_PH_MID      2'h2
`define DTRW_PH_LAST     2'h3
`define DTRW_ADDR_W      8
`endif

/* dtrw_pkg.sv */
package dtrw_pkg;
  typedef enum logic [3:0] {
    W_IDLE = 4'h1,
    W_PRE  = 4'h2,
    W_DATA = 4'h4,
    W_POST = 4'h8
  } dtrw_wr_state_t;
  typedef enum logic [4:0] {
    R_IDLE   = 5'h01,
    R_PRESET = 5'h02,
    R_HALT   = 5'h04,
    R_LOCK   = 5'h08,
    R_DATA   = 5'h10
  } dtrw_rd_state_t;
endpackage

/* dtrw_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------
// controller model
// ----------------
module dtrw_ctrl_model (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_bits,
  input  wire logic       i_buf_ready,
  output logic            o_write_cmd,
  output logic            o_wr_clk,
  output logic            o_wr_data,
  output logic            o_done
);
  // one bit per write-clock rise, msb first, waiting for buffer room
  initial begin
    o_write_cmd = 1'b0;
    o_wr_clk    = 1'b0;
    o_wr_data   = 1'b0;
    o_done      = 1'b1;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        @(negedge i_clk);
        o_done      = 1'b0;
        o_write_cmd = 1'b1;
        for (int i = 7; i >= 0; i--) begin
          for (int k = 0; k < 200 && i_buf_ready !== 1'b1; k++) @(negedge i_clk);
          o_wr_data = i_bits[i];
          o_wr_clk  = 1'b1;
          repeat (2) @(negedge i_clk);
          o_wr_clk  = 1'b0;
          o_wr_data = ~o_wr_data; // data not valid away from the clock rise
          repeat (2) @(negedge i_clk);
        end
        o_write_cmd = 1'b0;
        o_done      = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* dtrw_channel_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------
// channel checker
// ---------------
module dtrw_channel_chk #(
  parameter int PRE_LEN = 16
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_at_speed,
  input  wire logic        i_illegal_addr,
  input  wire logic [7:0]  o_x_lines,
  input  wire logic [15:0] o_y_lines,
  input  wire logic [7:0]  o_spare_x,
  input  wire logic        o_write_current,
  input  wire logic        o_preamble_ser_n,
  input  wire logic        o_write_pulse,
  input  wire logic        o_threshold_diode_gate,
  input  wire logic        o_threshold_hold,
  input  wire logic        o_rd_clk,
  input  wire logic        o_rd_clk_en,
  input  wire logic        o_rd_data,
  input  wire logic        o_ready_n
);
  logic [7:0] gap_q;
  logic [7:0] gate_q;
  logic [7:0] ser_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // run lengths: cycles since a write pulse, peak gate open, preamble ones
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_q  <= 8'h00;
      gate_q <= 8'h00;
      ser_q  <= 8'h00;
    end else begin
      gap_q  <= (o_write_pulse || !o_write_current) ? 8'h00 : gap_q + 8'h01;
      gate_q <= o_threshold_diode_gate ? gate_q + 8'h01 : 8'h00;
      ser_q  <= o_preamble_ser_n ? 8'h00 : ser_q + 8'h01;
    end
  end
  // head selection
  decode_hot_a: assert property ($onehot0(o_x_lines) && $onehot0(o_y_lines)
    && ((|o_x_lines) == (|o_y_lines))) else $error("normal decode not one-hot");
  decode_excl_a: assert property (!((|o_x_lines) && (|o_spare_x)))
    else $error("normal and spare lines both driven");
  // write gating
  illegal_cut_a: assert property (i_illegal_addr [*4] |-> !o_write_current)
    else $error("write current with illegal address");
  notready_cut_a: assert property (!i_at_speed [*4] |-> !o_write_current && o_ready_n)
    else $error("write current or ready while not at speed");
  pre_first_a: assert property ($rose(o_write_current) |-> !o_preamble_ser_n)
    else $error("write did not open with a preamble one");
  ser_len_a: assert property (!o_preamble_ser_n |-> ser_q < (PRE_LEN - 1) * 4)
    else $error("preamble run of ones too long");
  // write encoder pulses
  pulse_single_a: assert property (o_write_pulse |=> !o_write_pulse)
    else $error("write pulse wider than one cycle");
  pulse_gap_a: assert property (o_write_current |-> gap_q < 8'h09)
    else $error("flux gap longer than two cells");
  // read side
  gate_len_a: assert property (o_threshold_diode_gate |-> gate_q < 8'h14)
    else $error("peak gate open beyond five cells");
  hold_excl_a: assert property (o_threshold_hold |-> !o_threshold_diode_gate)
    else $error("threshold held while peak gate open");
  rdclk_gate_a: assert property (o_rd_clk |-> o_rd_clk_en || $past(o_rd_clk_en))
    else $error("read clock without enable");
  rddata_flag_a: assert property ($rose(o_rd_data) |-> o_rd_clk_en)
    else $error("read data before flag");
endmodule
bind dtrw_channel dtrw_channel_chk #(.PRE_LEN(PRE_LEN)) u_chk (.*);
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
// -------------
// channel bench
// -------------
module tb;
  localparam int          PRE    = 4;
  localparam logic [15:0] STREAM = 16'hFD4C;
  logic        clk, nrst, unit_sel, spare_en, spare_y_sel, read_cmd, raw, go, done;
  logic        at_speed, bus_term, illegal, write_cmd, wr_clk, wr_data;
  logic [7:0]  track, bits, x_lines, spare_x;
  logic [6:0]  spare_addr;
  logic [2:0]  spare_x_sel, supply_ok;
  logic [15:0] y_lines;
  logic [1:0]  spare_y;
  logic        surf, buf_rdy, ser_n, wpulse, wcur, gate, sw_on, hold, sep_en, halt;
  logic        rd_data, rd_clk, rd_clk_en, ready_n, ill_out;
  int          n_fail, comparisons, np, nc, ns;

  dtrw_channel #(.PRE_LEN(PRE)) DUT (
    .i_clk(clk), .i_nrst(nrst), .i_unit_sel(unit_sel), .i_track_addr_in(track),
    .i_spare_en(spare_en), .i_spare_addr(spare_addr), .i_spare_x_sel(spare_x_sel),
    .i_spare_y_sel(spare_y_sel), .i_write_cmd(write_cmd), .i_wr_clk(wr_clk),
    .i_wr_data(wr_data), .i_read_cmd(read_cmd), .i_raw_read_pulses(raw),
    .i_supply_ok(supply_ok), .i_at_speed(at_speed), .i_bus_term(bus_term),
    .i_illegal_addr(illegal), .o_x_lines(x_lines), .o_y_lines(y_lines),
    .o_spare_x(spare_x), .o_spare_y(spare_y), .o_surface_select_bit(surf),
    .o_wr_buf_ready(buf_rdy), .o_preamble_ser_n(ser_n), .o_write_pulse(wpulse),
    .o_write_current(wcur), .o_threshold_diode_gate(gate), .o_threshold_switch_on(sw_on),
    .o_threshold_hold(hold), .o_separator_enable(sep_en), .o_osc_halt_restart(halt),
    .o_separator_pretrack_clock(), .o_sep_clk_x2(), .o_sep_clk_x1(), .o_phase_sample(),
    .o_deglitched_read_bits(), .o_rd_data(rd_data), .o_rd_clk(rd_clk),
    .o_rd_clk_en(rd_clk_en), .o_ready_n(ready_n), .o_illegal_out(ill_out)
  );
  dtrw_ctrl_model u_ctrl (
    .i_clk(clk), .i_go(go), .i_bits(bits), .i_buf_ready(buf_rdy),
    .o_write_cmd(write_cmd), .o_wr_clk(wr_clk), .o_wr_data(wr_data), .o_done(done)
  );

  // 100 ns clock
  always #50 clk = ~clk;

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and stop
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // pulses expected: one per 1, one per boundary between two zeros
  function automatic int exp_pulses(input logic [7:0] d);
    logic prev, cur;
    int   n;
    n    = 0;
    prev = 1'b1;
    for (int i = 0; i < PRE + 13; i++) begin
      cur = (i < PRE - 1) ? 1'b1 : (i < PRE) ? 1'b0 : (i < PRE + 8) ? d[PRE + 7 - i] : 1'b0;
      if (cur || !prev) n++;
      prev = cur;
    end
    return n;
  endfunction
  // count write pulses, current cycles and preamble-one cycles
  task automatic watch(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      if (wpulse === 1'b1) np++;
      if (wcur === 1'b1) nc++;
      if (ser_n === 1'b0) ns++;
    end
  endtask
  // start a controller write and clear the counters
  task automatic start_write(input logic [7:0] d);
    np = 0;
    nc = 0;
    ns = 0;
    bits = d;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask
  task automatic wait_done;
    repeat (2) @(negedge clk);
    for (int k = 0; k < 3000 && done !== 1'b1; k++) @(negedge clk);
    if (done !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask

  // address decode, surface bit and spare override
  task automatic t_decode;
    logic [7:0] a;
    for (int k = 0; k < 4; k++) begin
      a = 8'h13 + 8'h4B * k;
      track = a;
      repeat (4) @(negedge clk);
      check(y_lines, 16'h0001 << a[3:0]);
      check(x_lines, 8'h01 << a[6:4]);
      check(surf, a[7]);
    end
    spare_addr = a[6:0];
    spare_x_sel = 3'h5;
    spare_y_sel = 1'b1;
    spare_en = 1'b1;
    repeat (4) @(negedge clk);
    check({x_lines, spare_x}, 16'h0020);
    check({spare_y, surf}, {2'h2, a[7]});
    spare_en = 1'b0;
  endtask
  // each monitor alone drops ready; illegal leaves ready alone
  task automatic t_ready;
    for (int k = 0; k < 5; k++) begin
      {supply_ok, at_speed, bus_term} = 5'h1F ^ (5'h01 << k);
      repeat (4) @(negedge clk);
      check(ready_n, 1'b1);
    end
    {supply_ok, at_speed, bus_term} = 5'h1F;
    illegal = 1'b1;
    repeat (4) @(negedge clk);
    check({ready_n, ill_out}, 2'h1);
    illegal = 1'b0;
  endtask
  // full sector: preamble, data, postamble; address held meanwhile
  task automatic t_write;
    logic [7:0] a;
    a = track;
    start_write(8'h93);
    watch(20);
    track = ~a;
    watch(10);
    check(y_lines, 16'h0001 << a[3:0]);
    watch(120);
    check(16'(np), 16'(exp_pulses(8'h93)));
    check(16'(nc), 16'((PRE + 13) * 4));
    check(16'(ns), 16'((PRE - 1) * 4));
    wait_done();
  endtask
  // loss of speed mid-write kills write current
  task automatic t_notready;
    start_write(8'hFF);
    watch(30);
    check(wcur, 1'b1);
    at_speed = 1'b0;
    repeat (4) @(negedge clk);
    check({wcur, ready_n}, 2'h1);
    wait_done();
    at_speed = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // locked-out track and deselected unit never get write current
  task automatic t_blocked;
    illegal = 1'b1;
    start_write(8'h5A);
    watch(100);
    check(16'(nc), 16'h0000);
    check(ready_n, 1'b0);
    wait_done();
    repeat (40) @(negedge clk);
    illegal = 1'b0;
    unit_sel = 1'b0;
    start_write(8'h5A);
    watch(60);
    check({16'(nc)}, 16'h0000);
    check(buf_rdy, 1'b0);
    wait_done();
    unit_sel = 1'b1;
  endtask
  // read: preset, separator enable, flag, NRZ data, clock gating
  task automatic t_read;
    logic [7:0] sh;
    logic       found;
    logic       prev;
    int         k;
    sh = 8'h00;
    found = 1'b0;
    prev = 1'b0;
    read_cmd = 1'b1;
    for (k = 0; k < 80 && sep_en !== 1'b1; k++) begin
      @(negedge clk);
      if (k == 6) check({gate, sw_on}, 2'h3);
      if (k == 30) check({gate, hold}, 2'h1);
    end
    check(16'(k >= 36 && k <= 42), 16'h0001);
    repeat (2) @(negedge clk);
    check(halt, 1'b1);
    for (int i = 0; i < 80; i++) begin
      raw = (i % 4 == 0 && i < 64) ? STREAM[15 - i / 4] : 1'b0;
      @(negedge clk);
      if (rd_clk_en !== 1'b1) check(rd_data, 1'b0);
      if (rd_clk === 1'b1 && !prev) sh = {sh[6:0], rd_data};
      found = found | (sh == 8'hA6);
      prev = rd_clk;
    end
    check({found, rd_clk_en}, 2'h3);
    read_cmd = 1'b0;
    repeat (6) @(negedge clk);
    k = 0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      if (rd_clk !== 1'b0) k++;
    end
    check(16'(k), 16'h0000);
    check({sep_en, hold}, 2'h0);
  endtask

  // reset, scenarios, verdict
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    unit_sel = 1'b1;
    track = 8'h00;
    spare_en = 1'b0;
    spare_addr = 7'h00;
    spare_x_sel = 3'h0;
    spare_y_sel = 1'b0;
    read_cmd = 1'b0;
    raw = 1'b0;
    {supply_ok, at_speed, bus_term} = 5'h1F;
    illegal = 1'b0;
    go = 1'b0;
    bits = 8'h00;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_decode();
    t_ready();
    t_write();
    t_notready();
    t_blocked();
    t_read();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
